// ==== common/usib_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the serial status block.
`ifndef USIB_CFG_SVH
`define USIB_CFG_SVH

// Register select codes on the two address pins.
`define USIB_ADDR_DATA 2'h0
`define USIB_ADDR_STAT 2'h1
`define USIB_ADDR_MCTL 2'h2
`define USIB_ADDR_MSTAT 2'h3

// Line status bit positions.
`define USIB_ST_PE 0
`define USIB_ST_FE 1
`define USIB_ST_OE 2
`define USIB_ST_BRK 3
`define USIB_ST_MS 4
`define USIB_ST_TC 5
`define USIB_ST_TX_HOLDING_EMPTY 6
`define USIB_ST_DR 7
`define USIB_ST_RESET 8'h60
`define USIB_ST_RXUPD 8'h0F

// Modem control bit positions.
`define USIB_MC_DTR 0
`define USIB_MC_RTS 1
`define USIB_MC_GLOBAL_IRQ_ENABLE 2
`define USIB_MC_MODEM_IRQ_ENABLE 3
`define USIB_MC_REN 4
`define USIB_MC_MODE 5
`define USIB_MC_RESET 8'h00
`define USIB_MC_WMASK 8'h7F

// Line format bit positions.
`define USIB_LF_LEN 0
`define USIB_LF_STOP2 2
`define USIB_LF_PEN 3
`define USIB_LF_RXODD 4
`define USIB_LF_TXODD 5
`define USIB_LF_RESET 8'h00

// Modem input image bit positions.
`define USIB_MI_CTS 0
`define USIB_MI_DSR 1

// Pin synchroniser idle value and oversampling counts.
`define USIB_PINS_IDLE 16'h9807
`define USIB_TICK_LAST 4'hF
`define USIB_TICK_MID 4'h7
`define USIB_LEN_BASE 3'h4

`endif

// ==== common/usib_pkg.sv ====
// Types shared by the serial status block modules.
`default_nettype none
package usib_pkg;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_BREAK = 2'h1,
      MODE_ECHO = 2'h2,
      MODE_LOOP = 2'h3
   } usib_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_DATA = 3'h2,
      ST_PAR = 3'h3,
      ST_STOP = 3'h4
   } usib_state_t;

   typedef struct packed {
      logic [1:0] len;
      logic stop2;
      logic par_en;
      logic rx_odd;
      logic tx_odd;
   } usib_fmt_t;

   typedef struct packed {
      logic [7:0] data;
      logic par_err;
      logic frm_err;
      logic brk;
   } usib_rxchar_t;

   typedef struct packed {
      logic cs_n;
      logic [1:0] addr;
      logic rd_n;
      logic wr_n;
      logic [7:0] data;
      logic serial;
      logic cts_n;
      logic dsr_n;
   } usib_pins_t;

   // Mask of the data bits in use for a word length code (0 means 5 bits).
   function automatic logic [7:0] usib_len_mask(input logic [1:0] len);
      usib_len_mask = 8'hFF >> (2'h3 - len);
   endfunction

endpackage
`default_nettype wire

// ==== logic/usib_rx.sv ====
// Receive shift register with start detection, parity, framing and break checks.
`timescale 1ns/1ps
`default_nettype none
`include "usib_cfg.svh"
module usib_rx (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic tick,
   input wire logic rx_line,
   input wire usib_pkg::usib_fmt_t fmt,
   output logic done,
   output usib_pkg::usib_rxchar_t result
);
   usib_pkg::usib_state_t state;
   logic [3:0] tcnt;
   logic [2:0] bcnt;
   logic [7:0] shreg;
   logic par_acc;
   logic any_one;
   logic sample;

   assign sample = tick && (tcnt == `USIB_TICK_LAST);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= usib_pkg::ST_IDLE;
         tcnt <= 4'h0;
         bcnt <= 3'h0;
         shreg <= 8'h00;
         par_acc <= 1'b0;
         any_one <= 1'b0;
         done <= 1'b0;
         result <= '0;
      end else begin
         done <= 1'b0;
         if (tick) begin
            tcnt <= tcnt + 4'h1;
         end
         case (state)
            usib_pkg::ST_IDLE: begin
               tcnt <= 4'h0;
               if (tick && !rx_line) begin
                  state <= usib_pkg::ST_START;
               end
            end
            usib_pkg::ST_START: begin
               // Bit clock is aligned to the middle of the start bit.
               if (tick && tcnt == `USIB_TICK_MID) begin
                  tcnt <= 4'h0;
                  bcnt <= 3'h0;
                  par_acc <= 1'b0;
                  any_one <= 1'b0;
                  state <= rx_line ? usib_pkg::ST_IDLE : usib_pkg::ST_DATA;
               end
            end
            usib_pkg::ST_DATA: begin
               if (sample) begin
                  shreg <= {rx_line, shreg[7:1]};
                  par_acc <= par_acc ^ rx_line;
                  any_one <= any_one | rx_line;
                  bcnt <= bcnt + 3'h1;
                  if (bcnt == {1'b0, fmt.len} + `USIB_LEN_BASE) begin
                     state <= fmt.par_en ? usib_pkg::ST_PAR : usib_pkg::ST_STOP;
                  end
               end
            end
            usib_pkg::ST_PAR: begin
               if (sample) begin
                  par_acc <= par_acc ^ rx_line;
                  any_one <= any_one | rx_line;
                  state <= usib_pkg::ST_STOP;
               end
            end
            usib_pkg::ST_STOP: begin
               // Results are reported while the stop bit is sampled.
               if (sample) begin
                  done <= 1'b1;
                  result.data <= (shreg >> (2'h3 - fmt.len)) & usib_pkg::usib_len_mask(fmt.len);
                  result.frm_err <= !rx_line;
                  result.par_err <= fmt.par_en && (par_acc != fmt.rx_odd);
                  result.brk <= !(any_one || rx_line);
                  state <= usib_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= usib_pkg::ST_IDLE;
            end
         endcase
      end
   end
endmodule // usib_rx
`default_nettype wire

// ==== logic/usib_tx.sv ====
// Transmit shift register that takes the held character when free.
`timescale 1ns/1ps
`default_nettype none
`include "usib_cfg.svh"
module usib_tx (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic tick,
   input wire usib_pkg::usib_fmt_t fmt,
   input wire logic hold_valid,
   input wire logic [7:0] hold_data,
   input wire logic go_ok,
   output logic take,
   output logic done,
   output logic line
);
   usib_pkg::usib_state_t state;
   logic [3:0] tcnt;
   logic [2:0] bcnt;
   logic [7:0] shreg;
   logic par;
   logic second_stop;
   logic bit_end;

   assign bit_end = tick && (tcnt == `USIB_TICK_LAST);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= usib_pkg::ST_IDLE;
         tcnt <= 4'h0;
         bcnt <= 3'h0;
         shreg <= 8'h00;
         par <= 1'b0;
         second_stop <= 1'b0;
         take <= 1'b0;
         done <= 1'b0;
         line <= 1'b1;
      end else begin
         take <= 1'b0;
         done <= 1'b0;
         if (tick) begin
            tcnt <= tcnt + 4'h1;
         end
         case (state)
            usib_pkg::ST_IDLE: begin
               tcnt <= 4'h0;
               // A new character starts only while clear-to-send is asserted.
               if (hold_valid && go_ok) begin
                  take <= 1'b1;
                  shreg <= hold_data & usib_pkg::usib_len_mask(fmt.len);
                  par <= fmt.tx_odd;
                  bcnt <= 3'h0;
                  line <= 1'b0;
                  state <= usib_pkg::ST_START;
               end
            end
            usib_pkg::ST_START: begin
               if (bit_end) begin
                  line <= shreg[0];
                  state <= usib_pkg::ST_DATA;
               end
            end
            usib_pkg::ST_DATA: begin
               // Bit 0 goes out first.
               if (bit_end) begin
                  par <= par ^ shreg[0];
                  shreg <= shreg >> 1;
                  bcnt <= bcnt + 3'h1;
                  if (bcnt == {1'b0, fmt.len} + `USIB_LEN_BASE) begin
                     line <= fmt.par_en ? (par ^ shreg[0]) : 1'b1;
                     second_stop <= fmt.stop2;
                     state <= fmt.par_en ? usib_pkg::ST_PAR : usib_pkg::ST_STOP;
                  end else begin
                     line <= shreg[1];
                  end
               end
            end
            usib_pkg::ST_PAR: begin
               if (bit_end) begin
                  line <= 1'b1;
                  state <= usib_pkg::ST_STOP;
               end
            end
            usib_pkg::ST_STOP: begin
               if (bit_end) begin
                  second_stop <= 1'b0;
                  if (!second_stop) begin
                     done <= 1'b1;
                     state <= usib_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               state <= usib_pkg::ST_IDLE;
            end
         endcase
      end
   end
endmodule // usib_tx
`default_nettype wire

// ==== logic/usib_top.sv ====
// Status, interrupt and data buffer logic of the serial transceiver.
//
// Behaviour
// - Error flags updated once per character, at stop.
// - Overrun set when held character still unread.
// - Framing error on missing or short stop bit.
// - Parity error when computed parity mismatches setting.
// - All-zero frame, stop bit included, sets break flag and data ready.
// - Modem change flag; interrupt needs both enables.
// - Transmit complete flag; rising edge interrupts if enabled.
// - Empty and ready use own pins, never interrupt.
// - Status read clears flags and edge detector.
// - Modem inputs read back inverted.
// - Clear-to-send negated holds off next character.
// - Five to eight bits, right justified, zero filled.
// - Start-aligned bit clock; completion loads holding register unless held character still unread.
// - Transmitter shares length, own parity, bit 0 first.
// - Modem read clears edge detector, not the bits.
// - Complete edge detector fires on rising flag only; modem detector on every input change.
// - Flag setting deferred until status read ends.
// - Flag set before read and recurring is cleared.
// - Interrupt output low while global enable clear.
// - Reset clears flags but sets complete and empty.
`timescale 1ns/1ps
`default_nettype none
`include "usib_cfg.svh"
module usib_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic baud16_tick,
   input wire logic cs_n,
   input wire logic [1:0] addr,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic serial_in,
   output logic serial_out,
   input wire logic cts_n,
   input wire logic dsr_n,
   output logic rts_n,
   output logic dtr_n,
   output logic data_ready,
   output logic tx_holding_empty,
   output logic irq_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   usib_pkg::usib_pins_t pin_raw;
   usib_pkg::usib_pins_t pin_s1;
   usib_pkg::usib_pins_t pin_s2;
   usib_pkg::usib_pins_t pin_s3;
   usib_pkg::usib_pins_t pin_q;

   // A bit follows its input once the second and third stages agree.
   function automatic logic [15:0] agree(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] q);
      agree = (a & b) | (q & (a | b));
   endfunction

   assign pin_raw = {cs_n, addr, rd_n, wr_n, data_in, serial_in, cts_n, dsr_n};

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_s1 <= `USIB_PINS_IDLE;
         pin_s2 <= `USIB_PINS_IDLE;
         pin_s3 <= `USIB_PINS_IDLE;
         pin_q <= `USIB_PINS_IDLE;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_q <= agree(pin_s2, pin_s3, pin_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus strobes.

   logic rd_act;
   logic wr_act;
   logic rd_act_d;
   logic wr_act_d;
   logic rd_start;
   logic rd_end;
   logic wr_end;
   logic [1:0] rd_addr;
   logic [1:0] wr_addr;
   logic [7:0] wr_data;
   logic usr_rd;
   logic msr_rd;
   logic usr_rd_end;
   logic msr_rd_end;
   logic rbr_rd_end;

   // True on the first cycle after an access to the given register ends.
   function automatic logic access_end(input logic strobe_end, input logic [1:0] a,
                                       input logic [1:0] code);
      access_end = strobe_end && (a == code);
   endfunction

   assign rd_act = !pin_q.cs_n && !pin_q.rd_n;
   assign wr_act = !pin_q.cs_n && !pin_q.wr_n;
   assign rd_start = rd_act && !rd_act_d;
   assign rd_end = !rd_act && rd_act_d;
   assign wr_end = !wr_act && wr_act_d;
   assign usr_rd = rd_act && (pin_q.addr == `USIB_ADDR_STAT);
   assign msr_rd = rd_act && (pin_q.addr == `USIB_ADDR_MSTAT);
   assign usr_rd_end = access_end(rd_end, rd_addr, `USIB_ADDR_STAT);
   assign msr_rd_end = access_end(rd_end, rd_addr, `USIB_ADDR_MSTAT);
   assign rbr_rd_end = access_end(rd_end, rd_addr, `USIB_ADDR_DATA);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_act_d <= 1'b0;
         wr_act_d <= 1'b0;
         rd_addr <= 2'h0;
         wr_addr <= 2'h0;
         wr_data <= 8'h00;
      end else begin
         rd_act_d <= rd_act;
         wr_act_d <= wr_act;
         if (rd_act) begin
            rd_addr <= pin_q.addr;
         end
         if (wr_act) begin
            wr_addr <= pin_q.addr;
            wr_data <= pin_q.data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers.

   logic [7:0] line_format_reg;
   logic [7:0] modem_control_reg;
   usib_pkg::usib_fmt_t fmt;
   usib_pkg::usib_mode_t mode;
   logic global_irq_enable;
   logic modem_irq_enable;
   logic rx_enable;

   assign fmt.len = line_format_reg[`USIB_LF_LEN +: 2];
   assign fmt.stop2 = line_format_reg[`USIB_LF_STOP2];
   assign fmt.par_en = line_format_reg[`USIB_LF_PEN];
   assign fmt.rx_odd = line_format_reg[`USIB_LF_RXODD];
   assign fmt.tx_odd = line_format_reg[`USIB_LF_TXODD];
   assign mode = usib_pkg::usib_mode_t'(modem_control_reg[`USIB_MC_MODE +: 2]);
   assign global_irq_enable = modem_control_reg[`USIB_MC_GLOBAL_IRQ_ENABLE];
   assign modem_irq_enable = modem_control_reg[`USIB_MC_MODEM_IRQ_ENABLE];
   assign rx_enable = modem_control_reg[`USIB_MC_REN];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         line_format_reg <= `USIB_LF_RESET;
         modem_control_reg <= `USIB_MC_RESET;
      end else begin
         if (access_end(wr_end, wr_addr, `USIB_ADDR_STAT)) begin
            line_format_reg <= wr_data;
         end
         if (access_end(wr_end, wr_addr, `USIB_ADDR_MCTL)) begin
            modem_control_reg <= wr_data & `USIB_MC_WMASK;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rts_n <= 1'b1;
         dtr_n <= 1'b1;
      end else begin
         rts_n <= !modem_control_reg[`USIB_MC_RTS];
         dtr_n <= !modem_control_reg[`USIB_MC_DTR];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver and receive holding register.

   logic rx_line;
   logic tx_line;
   logic rx_done;
   usib_pkg::usib_rxchar_t rx_res;
   logic [7:0] rx_holding_reg;

   assign rx_line = !rx_enable ? 1'b1 : (mode == usib_pkg::MODE_LOOP) ? tx_line : pin_q.serial;

   usib_rx u_rx (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(baud16_tick),
      .rx_line(rx_line),
      .fmt(fmt),
      .done(rx_done),
      .result(rx_res)
   );

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rx_holding_reg <= 8'h00;
         data_ready <= 1'b0;
      end else if (rx_done && (!data_ready || rbr_rd_end)) begin
         rx_holding_reg <= rx_res.data;
         data_ready <= 1'b1;
      end else if (rbr_rd_end) begin
         data_ready <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmitter and transmit holding register.

   logic [7:0] tx_holding_reg;
   logic tx_take;
   logic tx_done;
   logic tx_go;

   assign tx_go = !pin_q.cts_n && (mode != usib_pkg::MODE_ECHO);

   usib_tx u_tx (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(baud16_tick),
      .fmt(fmt),
      .hold_valid(!tx_holding_empty),
      .hold_data(tx_holding_reg),
      .go_ok(tx_go),
      .take(tx_take),
      .done(tx_done),
      .line(tx_line)
   );

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tx_holding_reg <= 8'h00;
         tx_holding_empty <= 1'b1;
      end else if (access_end(wr_end, wr_addr, `USIB_ADDR_DATA)) begin
         tx_holding_reg <= wr_data;
         tx_holding_empty <= 1'b0;
      end else if (tx_take) begin
         tx_holding_empty <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         serial_out <= 1'b1;
      end else begin
         case (mode)
            usib_pkg::MODE_ECHO: serial_out <= pin_q.serial;
            usib_pkg::MODE_LOOP: serial_out <= 1'b1;
            usib_pkg::MODE_BREAK: serial_out <= 1'b0;
            default: serial_out <= tx_line;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Modem inputs.

   logic cts_prev;
   logic dsr_prev;
   logic modem_chg;

   assign modem_chg = (pin_q.cts_n != cts_prev) || (pin_q.dsr_n != dsr_prev);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cts_prev <= 1'b1;
         dsr_prev <= 1'b1;
      end else begin
         cts_prev <= pin_q.cts_n;
         dsr_prev <= pin_q.dsr_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Line status flags.

   logic [7:0] line_status_reg;
   logic [7:0] st_pend;
   logic [7:0] st_evt;
   logic [7:0] st_upd;

   always_comb begin
      st_evt = 8'h00;
      st_upd = rx_done ? `USIB_ST_RXUPD : 8'h00;
      st_evt[`USIB_ST_OE] = rx_done && data_ready && !rbr_rd_end;
      st_evt[`USIB_ST_FE] = rx_done && rx_res.frm_err;
      st_evt[`USIB_ST_PE] = rx_done && rx_res.par_err;
      st_evt[`USIB_ST_BRK] = rx_done && rx_res.brk;
      st_evt[`USIB_ST_DR] = rx_done && (!data_ready || rbr_rd_end);
      st_evt[`USIB_ST_MS] = modem_chg;
      st_evt[`USIB_ST_TC] = tx_done && tx_holding_empty;
      st_evt[`USIB_ST_TX_HOLDING_EMPTY] = tx_take;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         line_status_reg <= `USIB_ST_RESET;
         st_pend <= 8'h00;
      end else if (usr_rd) begin
         st_pend <= st_pend | st_evt;
      end else if (usr_rd_end) begin
         line_status_reg <= (st_pend | st_evt) & ~line_status_reg;
         st_pend <= 8'h00;
      end else begin
         line_status_reg <= (line_status_reg & ~st_upd) | st_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt edge detectors.

   logic tc_prev;
   logic tc_edge;
   logic ms_edge;
   logic ms_pend;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tc_prev <= 1'b1;
         tc_edge <= 1'b1;
      end else begin
         tc_prev <= line_status_reg[`USIB_ST_TC];
         tc_edge <= (tc_edge && !usr_rd_end) ||
                    (line_status_reg[`USIB_ST_TC] && !tc_prev);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ms_edge <= 1'b0;
         ms_pend <= 1'b0;
      end else if (msr_rd) begin
         ms_pend <= ms_pend || modem_chg;
      end else if (msr_rd_end) begin
         ms_edge <= (ms_pend || modem_chg) && !ms_edge;
         ms_pend <= 1'b0;
      end else if (modem_chg) begin
         ms_edge <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= global_irq_enable &&
                    (tc_edge || (modem_irq_enable && ms_edge));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else begin
         data_oe <= rd_act;
         if (rd_start) begin
            case (pin_q.addr)
               `USIB_ADDR_DATA: data_out <= rx_holding_reg;
               `USIB_ADDR_STAT: data_out <= line_status_reg;
               `USIB_ADDR_MCTL: data_out <= modem_control_reg;
               `USIB_ADDR_MSTAT: begin
                  data_out <= 8'h00;
                  data_out[`USIB_MI_CTS] <= !pin_q.cts_n;
                  data_out[`USIB_MI_DSR] <= !pin_q.dsr_n;
               end
               default: data_out <= 8'h00;
            endcase
         end
      end
   end

endmodule // usib_top
`default_nettype wire

// ==== test/usib_monitor.sv ====
// Port checker of the serial status block.
`timescale 1ns/1ps
`default_nettype none
module usib_monitor (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic serial_out,
   input wire logic data_ready,
   input wire logic tx_holding_empty,
   input wire logic irq_out
);
   logic [3:0] age;
   // Counts cycles since the last bus strobe.
   always_ff @(posedge clk_sys) begin
      if (reset || (!cs_n && !(rd_n && wr_n))) begin
         age <= 4'h0;
      end else if (age != 4'hF) begin
         age <= age + 4'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   AST_RST: assert property (disable iff (1'b0) reset |=>
      tx_holding_empty && !data_ready && !irq_out && serial_out) else $error("reset values");
   AST_IRQ_HOLD: assert property ($fell(irq_out) |-> age < 4'hA)
      else $error("irq fell without read");
   AST_DR_PIN: assert property ($fell(data_ready) |-> age < 4'hA)
      else $error("ready fell without read");
   AST_TX_HOLDING_EMPTY_PIN: assert property ($fell(tx_holding_empty) |-> age < 4'hA)
      else $error("empty fell without write");
   AST_OE_RISE: assert property ($rose(data_oe) |-> !$past(rd_n, 2) && !$past(cs_n, 2))
      else $error("bus driven without read");
   AST_OE_HOLD: assert property (data_oe && !rd_n && !cs_n |=> data_oe)
      else $error("bus dropped during read");
   AST_OE_FALL: assert property ($rose(rd_n) |-> ##[1:8] !data_oe)
      else $error("bus held after read");
   AST_DOUT: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
      else $error("read data moved");
   AST_TX_START: assert property ($rose(tx_holding_empty) |-> ##[0:40] !serial_out)
      else $error("no start bit");
   cover property ($rose(irq_out));
   cover property ($rose(data_ready));
   cover property ($fell(tx_holding_empty));
endmodule // usib_monitor
bind usib_top usib_monitor i_usib_monitor (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n),
   .rd_n(rd_n), .wr_n(wr_n), .data_out(data_out), .data_oe(data_oe), .serial_out(serial_out),
   .data_ready(data_ready), .tx_holding_empty(tx_holding_empty), .irq_out(irq_out));
`default_nettype wire

// ==== test/usib_modem.sv ====
// Modem side model: drives the receive line and the modem inputs.
`timescale 1ns/1ps
`default_nettype none
module usib_modem (
   input wire logic clk_sys,
   output logic serial_in,
   output logic cts_n,
   output logic dsr_n
);
   initial begin
      serial_in = 1'b1;
      cts_n = 1'b1;
      dsr_n = 1'b1;
   end
   task automatic lines(input logic c, input logic s);
      @(posedge clk_sys);
      #1;
      cts_n = c;
      dsr_n = s;
   endtask
   // Sends a frame of n bits, bit 0 first, at 32 cycles a bit.
   task automatic send(input logic [7:0] d, input int n, input logic stp);
      int i;
      for (i = -1; i < n; i++) begin
         @(posedge clk_sys);
         #1 serial_in = (i < 0) ? 1'b0 : d[i];
         repeat (31) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      #1 serial_in = stp;
      repeat (24) @(posedge clk_sys);
      #1 serial_in = 1'b1;
      repeat (40) @(posedge clk_sys);
   endtask
endmodule // usib_modem
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench of the serial status block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic baud16_tick = 1'b0;
   logic cs_n = 1'b1;
   logic [1:0] addr = 2'h0;
   logic rd_n = 1'b1;
   logic wr_n = 1'b1;
   logic [7:0] data_in = 8'h00;
   logic [7:0] data_out, got, d;
   logic data_oe, serial_in, serial_out, cts_n, dsr_n, rts_n, dtr_n, data_ready;
   logic tx_holding_empty, irq_out;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   always #50 clk_sys = ~clk_sys;
   usib_top i_usib_top (.clk_sys(clk_sys), .reset(reset), .baud16_tick(baud16_tick),
      .cs_n(cs_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .serial_in(serial_in), .serial_out(serial_out),
      .cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n), .dtr_n(dtr_n), .data_ready(data_ready),
      .tx_holding_empty(tx_holding_empty), .irq_out(irq_out));
   usib_modem i_usib_modem (.clk_sys(clk_sys), .serial_in(serial_in), .cts_n(cts_n),
      .dsr_n(dsr_n));
   task automatic end_of_test();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) #1 baud16_tick = ~baud16_tick;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         end_of_test();
      end
   end
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk8({7'h0, g}, {7'h0, e});
   endtask
   function automatic logic [7:0] keep(input logic [7:0] v, input int n);
      keep = v & (8'hFF >> (8 - n));
   endfunction
   task automatic acc(input logic [1:0] a, input logic wr, input logic [7:0] v);
      @(posedge clk_sys);
      #1;
      addr = a;
      data_in = v;
      cs_n = 1'b0;
      rd_n = wr;
      wr_n = !wr;
      repeat (8) @(posedge clk_sys);
      got = data_out;
      #1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [1:0] a, input logic [7:0] e);
      acc(a, 1'b0, 8'h00);
      chk8(got, e);
   endtask
   task automatic wait_on(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   initial begin
      int i;
      void'($urandom(32'h6776));
      repeat (6) @(posedge clk_sys);
      #1 reset = 1'b0;
      chk1(tx_holding_empty, 1'b1);
      rdc(2'h1, 8'h60);
      rdc(2'h1, 8'h00);
      chk1(tx_holding_empty, 1'b1);
      acc(2'h1, 1'b1, 8'h03);
      acc(2'h2, 1'b1, 8'h14);
      chk1(irq_out, 1'b0);
      $display("test reset done");
      i_usib_modem.lines(1'b0, 1'b0);
      repeat (8) @(posedge clk_sys);
      chk1(irq_out, 1'b0);
      acc(2'h2, 1'b1, 8'h1C);
      chk1(irq_out, 1'b1);
      rdc(2'h3, 8'h03);
      chk1(irq_out, 1'b0);
      rdc(2'h1, 8'h10);
      acc(2'h2, 1'b1, 8'h14);
      $display("test modem done");
      d = 8'($urandom);
      acc(2'h0, 1'b1, d);
      wait_on(serial_out, 1'b0);
      repeat (16) @(posedge clk_sys);
      for (i = 0; i < 8; i++) begin
         repeat (32) @(posedge clk_sys);
         got[i] = serial_out;
      end
      chk8(got, d);
      wait_on(irq_out, 1'b1);
      chk1(irq_out, 1'b1);
      rdc(2'h1, 8'h60);
      chk1(irq_out, 1'b0);
      acc(2'h3, 1'b1, 8'($urandom));
      acc(2'h2, 1'b1, 8'h33);
      rdc(2'h1, 8'h00);
      rdc(2'h2, 8'h33);
      chk8({5'h00, serial_out, rts_n, dtr_n}, 8'h00);
      acc(2'h2, 1'b1, 8'h17);
      $display("test transmit done");
      for (i = 0; i < 4; i++) begin
         acc(2'h1, 1'b1, 8'(i));
         d = 8'($urandom);
         i_usib_modem.send(d, 5 + i, 1'b1);
         wait_on(data_ready, 1'b1);
         chk1(irq_out, 1'b0);
         rdc(2'h1, 8'h80);
         chk1(data_ready, 1'b1);
         rdc(2'h0, keep(d, 5 + i));
         chk1(data_ready, 1'b0);
      end
      i_usib_modem.send(8'h00, 8, 1'b0);
      rdc(2'h1, 8'h8A);
      i_usib_modem.send(8'($urandom), 8, 1'b1);
      acc(2'h1, 1'b0, 8'h00);
      chk8(got & 8'h0F, 8'h04);
      rdc(2'h0, 8'h00);
      acc(2'h1, 1'b1, 8'h0A);
      d = 8'($urandom);
      i_usib_modem.send(d, 8, 1'b1);
      rdc(2'h1, {1'b1, 6'h00, ^d});
      rdc(2'h0, keep(d, 7));
      $display("test receive done");
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
